// ==== rtl/sip_top.sv ====
// Purpose: Serial input parser working one input item at a time.
// Assumes: Receiver, program and result sink share clk_i.
// Notes:   Pattern array reads are combinational on pat_idx_o.
module sip_top
   import sip_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Item list from the program
   input  wire logic        item_valid_i,
   input  wire sip_item_s   item_i,
   output      logic        item_ready_o,
   output      logic        item_done_o,
   // Byte receiver
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   output      logic        rx_ready_o,
   // Pattern array read
   output      logic [7:0]  pat_idx_o,
   input  wire logic [7:0]  pat_byte_i,
   // Result writes
   output      logic        wr_valid_o,
   output      sip_result_s wr_o,
   input  wire logic        wr_ready_i
);

   function automatic logic is_digit(input logic [7:0] b);
      return (b >= CHAR_ZERO) && (b <= CHAR_NINE);
   endfunction : is_digit

   function automatic logic [15:0] store_val(input logic [15:0] v, input logic wide);
      return wide ? v : {8'h00, v[7:0]};
   endfunction : store_val

   function automatic logic [7:0] lit_byte(input logic [PAT_MAX*8-1:0] lit,
                                           input logic [7:0] pos);
      logic [7:0] b;
      b = BYTE_ZERO;
      for (int i = 0; i < PAT_MAX; i++) begin
         if (pos == 8'(i)) begin
            b = lit[i*8 +: 8];
         end
      end
      return b;
   endfunction : lit_byte

   sip_state_e  state_q, state_d;
   sip_item_s   item_q;
   logic [7:0]  pos_q, pos_d;
   logic [15:0] acc_q, acc_d;
   logic        seen_q, seen_d;
   logic [7:0]  first_q, first_d;
   logic [7:0]  hold_q;
   logic        hold_valid_q, hold_valid_d;
   logic        rx_ready_q;
   logic        item_ready_q;
   logic        item_done_q;
   logic        consume;
   logic        take;
   logic        push;
   sip_result_s res;
   logic        fifo_ready;
   logic [15:0] acc_next;
   logic [7:0]  cur_pat;
   logic [7:0]  lit_len;
   logic [7:0]  scr_len;
   logic        match_end;
   logic        is_match;

   assign item_ready_o = item_ready_q;
   assign item_done_o  = item_done_q;
   assign rx_ready_o   = rx_ready_q;
   assign pat_idx_o    = pos_q;

   assign take     = rx_valid_i & rx_ready_q;
   // Wrap-around accumulation keeps only the low 16 bits
   assign acc_next = acc_q * DIGIT_BASE + {8'h00, hold_q - CHAR_ZERO};
   assign lit_len  = {5'h00, (item_q.lit_len > LIT_MAX) ? LIT_MAX : item_q.lit_len};
   assign scr_len  = (item_q.count > SCRATCH_MAX) ? SCRATCH_MAX : item_q.count;
   assign is_match = (item_q.op == OP_MATCH_LIT) || (item_q.op == OP_MATCH_ARR);
   assign cur_pat  = (item_q.op == OP_MATCH_ARR) ? pat_byte_i : lit_byte(item_q.lit, pos_q);
   always_comb begin
      match_end = (pos_q == lit_len);
      if (item_q.op == OP_MATCH_ARR) begin
         match_end = (item_q.count != 8'h00) ? (pos_q == item_q.count)
                                             : (pat_byte_i == BYTE_ZERO);
      end
   end

   always_comb begin
      state_d = state_q;
      pos_d   = pos_q;
      acc_d   = acc_q;
      seen_d  = seen_q;
      first_d = first_q;
      consume = 1'b0;
      push    = 1'b0;
      res     = RESULT_RST;
      case (state_q)
         ST_IDLE: begin
            if (item_valid_i && item_ready_q) begin
               state_d = (item_i.op == OP_MATCH_ARR) ? ST_PREP : ST_WORK;
               pos_d   = 8'h00;
               acc_d   = 16'h0000;
               seen_d  = 1'b0;
               first_d = lit_byte(item_i.lit, 8'h00);
            end
         end
         ST_PREP: begin
            // Array head is fetched once so a restart needs no second read
            first_d = pat_byte_i;
            state_d = ST_WORK;
         end
         ST_WORK: begin
            case (item_q.op)
               OP_CONV: begin
                  if (hold_valid_q && fifo_ready) begin
                     consume = 1'b1;
                     if (is_digit(hold_q)) begin
                        seen_d = 1'b1;
                        acc_d  = acc_next;
                        pos_d  = pos_q + 8'h01;
                        if (item_q.count != 8'h00 && pos_q + 8'h01 == item_q.count) begin
                           push     = 1'b1;
                           res.tgt  = TGT_VAR;
                           res.wide = item_q.wide;
                           res.addr = item_q.target;
                           res.data = store_val(acc_next, item_q.wide);
                           state_d  = ST_DONE;
                        end
                     end else if (seen_q) begin
                        push     = 1'b1;
                        res.tgt  = TGT_VAR;
                        res.wide = item_q.wide;
                        res.addr = item_q.target;
                        res.data = store_val(acc_q, item_q.wide);
                        state_d  = ST_DONE;
                     end
                  end
               end
               OP_TEXT: begin
                  if (pos_q == item_q.count) begin
                     state_d = ST_DONE;
                  end else if (hold_valid_q && fifo_ready) begin
                     consume = 1'b1;
                     if (item_q.term_en && hold_q == item_q.term) begin
                        state_d = ST_FILL;
                     end else begin
                        push     = 1'b1;
                        res.tgt  = TGT_ARRAY;
                        res.addr = pos_q;
                        res.data = {8'h00, hold_q};
                        pos_d    = pos_q + 8'h01;
                     end
                  end
               end
               OP_MATCH_LIT, OP_MATCH_ARR: begin
                  if (match_end) begin
                     state_d = ST_DONE;
                  end else if (hold_valid_q) begin
                     consume = 1'b1;
                     if (hold_q == cur_pat) begin
                        pos_d = pos_q + 8'h01;
                     end else begin
                        pos_d = (hold_q == first_q) ? 8'h01 : 8'h00;
                     end
                  end
               end
               OP_SKIP: begin
                  if (pos_q == item_q.count) begin
                     state_d = ST_DONE;
                  end else if (hold_valid_q) begin
                     consume = 1'b1;
                     pos_d   = pos_q + 8'h01;
                  end
               end
               OP_SCRATCH: begin
                  if (pos_q == scr_len) begin
                     state_d = ST_DONE;
                  end else if (hold_valid_q && fifo_ready) begin
                     consume  = 1'b1;
                     push     = 1'b1;
                     res.tgt  = TGT_SCRATCH;
                     res.addr = pos_q;
                     res.data = {8'h00, hold_q};
                     pos_d    = pos_q + 8'h01;
                  end
               end
               default: begin
                  state_d = ST_DONE;
               end
            endcase
         end
         ST_FILL: begin
            if (pos_q == item_q.count) begin
               state_d = ST_DONE;
            end else if (fifo_ready) begin
               push     = 1'b1;
               res.tgt  = TGT_ARRAY;
               res.addr = pos_q;
               pos_d    = pos_q + 8'h01;
            end
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q      <= ST_IDLE;
         item_ready_q <= 1'b1;
         item_done_q  <= 1'b0;
      end else begin
         state_q      <= state_d;
         item_ready_q <= (state_d == ST_IDLE);
         item_done_q  <= (state_d == ST_DONE);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         item_q <= ITEM_RST;
      end else if (item_valid_i && item_ready_q) begin
         item_q <= item_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pos_q   <= 8'h00;
         acc_q   <= 16'h0000;
         seen_q  <= 1'b0;
         first_q <= 8'h00;
      end else begin
         pos_q   <= pos_d;
         acc_q   <= acc_d;
         seen_q  <= seen_d;
         first_q <= first_d;
      end
   end

   // One-byte hold: the receiver stalls until the current byte is used
   assign hold_valid_d = take | (hold_valid_q & ~consume);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_q       <= 8'h00;
         hold_valid_q <= 1'b0;
         rx_ready_q   <= 1'b1;
      end else begin
         if (take) begin
            hold_q <= rx_data_i;
         end
         hold_valid_q <= hold_valid_d;
         rx_ready_q   <= ~hold_valid_d;
      end
   end

   sip_fifo #(
      .WIDTH ($bits(sip_result_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (push),
      .in_data_i   (res),
      .in_ready_o  (fifo_ready),
      .out_valid_o (wr_valid_o),
      .out_data_o  (wr_o),
      .out_ready_i (wr_ready_i)
   );

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_rx_one_byte: assert property (rx_ready_o |-> !hold_valid_q)
      else $error("receiver offered a byte while one is held");

   a_conv_keeps: assert property ((state_q == ST_WORK && item_q.op == OP_CONV &&
      item_q.count == 8'h00 && consume && is_digit(hold_q)) |=> state_q == ST_WORK)
      else $error("unlimited conversion stopped on a digit");

   a_byte_target: assert property ((push && res.tgt == TGT_VAR && !res.wide)
      |-> res.data[15:8] == 8'h00)
      else $error("byte target got upper bits");

   a_digit_limit: assert property ((state_q == ST_WORK && item_q.op == OP_CONV &&
      item_q.count != 8'h00) |-> pos_q < item_q.count)
      else $error("conversion exceeded its digit limit");

   a_term_kept: assert property ((push && state_q == ST_WORK && item_q.op == OP_TEXT &&
      item_q.term_en) |-> res.data[7:0] != item_q.term)
      else $error("terminator written into array");

   a_fill_zero: assert property ((push && state_q == ST_FILL)
      |-> (res.data == 16'h0000 && res.addr == pos_q))
      else $error("fill wrote a nonzero element");

   a_match_block: assert property ((state_q == ST_WORK && is_match && !match_end)
      |=> state_q != ST_DONE)
      else $error("match item finished before the pattern ended");

   a_skip_silent: assert property ((state_q == ST_WORK && item_q.op == OP_SKIP)
      |-> !push && pos_q <= item_q.count)
      else $error("skip item stored data or overran");

   a_scratch_range: assert property ((push && res.tgt == TGT_SCRATCH)
      |-> res.addr < SCRATCH_MAX)
      else $error("scratch address out of range");

   a_item_order: assert property ((item_valid_i && item_ready_o)
      |=> !item_ready_o [*2])
      else $error("second item accepted before the first ended");

   a_seek_idle: assert property ((state_q == ST_WORK && item_q.op == OP_CONV && !seen_q &&
      consume && !is_digit(hold_q)) |=> acc_q == 16'h0000)
      else $error("conversion accumulated a non-digit");

   c_text_early: cover property (state_q == ST_WORK ##1 state_q == ST_FILL);
   c_match_done: cover property (state_q == ST_WORK && is_match && match_end);
   c_conv_store: cover property (push && res.tgt == TGT_VAR);
   c_fifo_full:  cover property (wr_valid_o && !wr_ready_i && !fifo_ready);

endmodule : sip_top

// ==== rtl/sip_pkg.sv ====
// Purpose: Shared types and constants of the serial input parser.
// Assumes: Bytes arrive from a receiver on the same clock as the parser.
// Notes:   Item and result records travel as packed structs.
package sip_pkg;

   localparam int unsigned BYTE_W      = 8;
   localparam int unsigned VAR_W       = 16;
   localparam int unsigned PAT_MAX     = 6;
   localparam int unsigned FIFO_DEPTH  = 4;

   localparam logic [7:0]  SCRATCH_MAX = 8'h7E;
   localparam logic [2:0]  LIT_MAX     = 3'h6;
   localparam logic [15:0] DIGIT_BASE  = 16'h000A;
   localparam logic [7:0]  CHAR_ZERO   = 8'h30;
   localparam logic [7:0]  CHAR_NINE   = 8'h39;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;

   typedef enum logic [2:0] {
      OP_CONV      = 3'h0,
      OP_TEXT      = 3'h1,
      OP_MATCH_LIT = 3'h2,
      OP_MATCH_ARR = 3'h3,
      OP_SKIP      = 3'h4,
      OP_SCRATCH   = 3'h5
   } sip_op_e;

   typedef enum logic [1:0] {
      TGT_VAR     = 2'h0,
      TGT_ARRAY   = 2'h1,
      TGT_SCRATCH = 2'h2
   } sip_tgt_e;

   // Gray codes along idle, prep, work, fill, done
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_PREP = 3'h1,
      ST_WORK = 3'h3,
      ST_FILL = 3'h2,
      ST_DONE = 3'h6
   } sip_state_e;

   typedef struct packed {
      sip_op_e                 op;
      logic                    wide;
      logic [7:0]              target;
      logic [7:0]              count;
      logic                    term_en;
      logic [7:0]              term;
      logic [PAT_MAX*8-1:0]    lit;
      logic [2:0]              lit_len;
   } sip_item_s;

   typedef struct packed {
      sip_tgt_e                tgt;
      logic                    wide;
      logic [7:0]              addr;
      logic [VAR_W-1:0]        data;
   } sip_result_s;

   localparam sip_result_s RESULT_RST = '0;
   localparam sip_item_s   ITEM_RST   = '0;

endpackage : sip_pkg

// ==== rtl/sip_fifo.sv ====
// Purpose: Small shifting FIFO for parser results.
// Assumes: Single clock; head entry is always slot 0.
// Notes:   Head data and valid come straight from flops.
module sip_fifo #(
   parameter int unsigned WIDTH = 27,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // Filling side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output      logic             in_ready_o,
   // Draining side
   output      logic             out_valid_o,
   output      logic [WIDTH-1:0] out_data_o,
   input  wire logic             out_ready_i
);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [DEPTH-1:0] vld_q;
   logic             pop;
   logic             push;

   assign pop         = vld_q[0] & out_ready_i;
   // Full may still accept when the head leaves in the same cycle
   assign in_ready_o  = ~vld_q[DEPTH-1] | out_ready_i;
   assign push        = in_valid_i & in_ready_o;
   assign out_valid_o = vld_q[0];
   assign out_data_o  = mem_q[0];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vld_q <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            logic             sv;
            logic             sp;
            logic [WIDTH-1:0] sd;
            int               nx;
            int               pv;
            // Clamped neighbour indices keep every select inside the array
            nx = (i < DEPTH-1) ? i+1 : i;
            pv = (i == 0) ? 0 : i-1;
            sv = vld_q[i];
            sd = mem_q[i];
            sp = (i == 0) ? 1'b1 : vld_q[pv];
            if (pop) begin
               sv = (i < DEPTH-1) ? vld_q[nx] : 1'b0;
               sd = mem_q[nx];
               sp = vld_q[i];
            end
            if (push && !sv && sp) begin
               sv = 1'b1;
               sd = in_data_i;
            end
            vld_q[i] <= sv;
            mem_q[i] <= sd;
         end
      end
   end

endmodule : sip_fifo

// ==== test/sip_sender.sv ====
// Purpose: Model of the serial byte sender in front of the parser.
// Assumes: The bench queues bytes with push; gap slows the sender.
// Notes:   Idle data shows the inverted last byte, never a stale copy.
module sip_sender (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Receiver handshake
   input  wire logic       rx_ready_i,
   output      logic       rx_valid_o,
   output      logic [7:0] rx_data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0]  tx_q[$];
   int unsigned gap = 0;
   int unsigned lost = 0;
   int unsigned wait_n;

   task automatic push(input logic [7:0] b);
      tx_q.push_back(b);
   endtask : push

   initial begin
      rx_valid_o = 1'b0;
      rx_data_o  = 8'h00;
      forever begin
         @(posedge clk_i);
         if (rst_n_i === 1'b1 && tx_q.size() > 0) begin
            #1;
            rx_valid_o = 1'b1;
            rx_data_o  = tx_q.pop_front();
            // Held until the edge that takes it
            wait_n = 0;
            do begin
               @(posedge clk_i);
               wait_n++;
            end while (rx_ready_i !== 1'b1 && wait_n < 4000);
            // A byte never taken is counted and dropped so the bench can report it
            if (rx_ready_i !== 1'b1) lost++;
            #1;
            rx_valid_o = 1'b0;
            rx_data_o  = ~rx_data_o;
            repeat (gap) @(posedge clk_i);
         end
      end
   end
endmodule : sip_sender

// ==== test/sip_top_tb_top.sv ====
// Purpose: Self-checking bench of the serial input parser.
// Assumes: Sink stalls 3 of every 5 cycles so the result FIFO fills.
// Notes:   Pattern array answers combinationally on pat_idx_o.
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
   $display("wrong value %s expected %h seen %h", n, e, a); end end
module sip_top_tb_top
   import sip_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i;
   logic        rst_n_i;
   logic        item_valid_i = 1'b0;
   sip_item_s   item_i       = ITEM_RST;
   logic        item_ready_o;
   logic        item_done_o;
   logic        rx_valid_i;
   logic [7:0]  rx_data_i;
   logic        rx_ready_o;
   logic [7:0]  pat_idx_o;
   logic [7:0]  pat_byte_i;
   logic        wr_valid_o;
   sip_result_s wr_o;
   logic        wr_ready_i   = 1'b0;
   logic [7:0]  pat_mem [256];
   logic [15:0] var_mem [256];
   sip_result_s got_q[$];
   int          fails        = 0;
   int          checked      = 0;
   int          ready_cnt    = 0;

   sip_top i_sip_top (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .item_valid_i (item_valid_i),
      .item_i       (item_i),
      .item_ready_o (item_ready_o),
      .item_done_o  (item_done_o),
      .rx_valid_i   (rx_valid_i),
      .rx_data_i    (rx_data_i),
      .rx_ready_o   (rx_ready_o),
      .pat_idx_o    (pat_idx_o),
      .pat_byte_i   (pat_byte_i),
      .wr_valid_o   (wr_valid_o),
      .wr_o         (wr_o),
      .wr_ready_i   (wr_ready_i)
   );

   sip_sender i_sip_sender (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .rx_ready_i (rx_ready_o),
      .rx_valid_o (rx_valid_i),
      .rx_data_o  (rx_data_i)
   );

   assign pat_byte_i = pat_mem[pat_idx_o];

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // Sink applies variable stores in arrival order
   always @(posedge clk_i) begin
      if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
         got_q.push_back(wr_o);
         if (wr_o.tgt == TGT_VAR) var_mem[wr_o.addr] = wr_o.data;
      end
      ready_cnt++;
      #1 wr_ready_i = (ready_cnt % 5) < 2;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   task automatic give_up(input string what);
      fails++;
      $display("wrong value %s expected done seen timeout", what);
      summarize();
   endtask : give_up

   task automatic send(input string s);
      foreach (s[k]) i_sip_sender.push(s[k]);
   endtask : send

   task automatic run(input sip_op_e op, input logic wide, input logic [7:0] tgt,
                      input logic [7:0] cnt, input logic ten, input logic [7:0] term,
                      input string lit);
      sip_item_s it;
      int        n;
      it = ITEM_RST;
      it.op = op;
      it.wide = wide;
      it.target = tgt;
      it.count = cnt;
      it.term_en = ten;
      it.term = term;
      foreach (lit[k]) it.lit[8*k +: 8] = lit[k];
      it.lit_len = 3'(lit.len());
      @(posedge clk_i);
      #1;
      item_valid_i = 1'b1;
      item_i = it;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
         if (n > 2000) give_up("item taken");
      end while (item_ready_o !== 1'b1);
      #1;
      item_valid_i = 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
         if (n > 4000) give_up("item done");
      end while (item_done_o !== 1'b1);
   endtask : run

   task automatic expect_wr(input sip_tgt_e t, input logic [7:0] a, input logic [15:0] d,
                            input logic [15:0] m);
      sip_result_s r;
      int          n;
      n = 0;
      while (got_q.size() == 0) begin
         @(posedge clk_i);
         n++;
         if (n > 400) give_up("result write");
      end
      r = got_q.pop_front();
      `CHK("result target", t, r.tgt)
      `CHK("result address", a, r.addr)
      // Mask gives the target width: upper bits must arrive cleared
      `CHK("result width", m[8], r.wide)
      `CHK("result data", d & m, r.data)
   endtask : expect_wr

   task automatic end_test(input string name);
      repeat (8) @(posedge clk_i);
      `CHK("stray writes", 0, got_q.size())
      `CHK("sender stalls", 0, i_sip_sender.lost)
      $display("test %s done", name);
   endtask : end_test

   task automatic t_conv();
      send("ab70000x300 ");
      run(OP_CONV, 1'b1, 8'h01, 8'h00, 1'b0, 8'h00, "");
      expect_wr(TGT_VAR, 8'h01, 16'h1170, 16'hFFFF);
      run(OP_CONV, 1'b0, 8'h02, 8'h00, 1'b0, 8'h00, "");
      expect_wr(TGT_VAR, 8'h02, 16'h012C, 16'h00FF);
      end_test("conversion");
   endtask : t_conv

   task automatic t_limit();
      send("9912 4 ");
      run(OP_CONV, 1'b1, 8'h05, 8'h02, 1'b0, 8'h00, "");
      expect_wr(TGT_VAR, 8'h05, 16'h0063, 16'hFFFF);
      run(OP_SKIP, 1'b0, 8'h00, 8'h02, 1'b0, 8'h00, "");
      run(OP_CONV, 1'b1, 8'h05, 8'h00, 1'b0, 8'h00, "");
      expect_wr(TGT_VAR, 8'h05, 16'h0004, 16'hFFFF);
      `CHK("final variable", 16'h0004, var_mem[5])
      end_test("digit limit");
   endtask : t_limit

   task automatic t_text();
      send("hi*abcd");
      run(OP_TEXT, 1'b0, 8'h03, 8'h04, 1'b1, "*", "");
      expect_wr(TGT_ARRAY, 8'h00, "h", 16'h00FF);
      expect_wr(TGT_ARRAY, 8'h01, "i", 16'h00FF);
      expect_wr(TGT_ARRAY, 8'h02, 16'h0000, 16'h00FF);
      expect_wr(TGT_ARRAY, 8'h03, 16'h0000, 16'h00FF);
      run(OP_TEXT, 1'b0, 8'h03, 8'h03, 1'b1, "*", "");
      for (int k = 0; k < 3; k++) expect_wr(TGT_ARRAY, 8'(k), 16'(8'h61 + k), 16'h00FF);
      run(OP_SKIP, 1'b0, 8'h00, 8'h01, 1'b0, 8'h00, "");
      end_test("text");
   endtask : t_text

   task automatic t_match();
      // Slow sender exercises the waiting side
      i_sip_sender.gap = 3;
      send("sesameSESAMExXYZ7 ");
      run(OP_MATCH_LIT, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, "SESAME");
      run(OP_MATCH_LIT, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, "XYZ");
      run(OP_CONV, 1'b1, 8'h07, 8'h00, 1'b0, 8'h00, "");
      expect_wr(TGT_VAR, 8'h07, 16'h0007, 16'hFFFF);
      i_sip_sender.gap = 0;
      end_test("literal match");
   endtask : t_match

   task automatic t_array();
      pat_mem[0] = "a";
      pat_mem[1] = "b";
      pat_mem[2] = 8'h00;
      send("aab5 cdx6 ");
      run(OP_MATCH_ARR, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00, "");
      run(OP_CONV, 1'b1, 8'h08, 8'h00, 1'b0, 8'h00, "");
      expect_wr(TGT_VAR, 8'h08, 16'h0005, 16'hFFFF);
      pat_mem[0] = "c";
      pat_mem[1] = "d";
      pat_mem[2] = "Q";
      run(OP_MATCH_ARR, 1'b0, 8'h00, 8'h02, 1'b0, 8'h00, "");
      run(OP_CONV, 1'b1, 8'h08, 8'h00, 1'b0, 8'h00, "");
      expect_wr(TGT_VAR, 8'h08, 16'h0006, 16'hFFFF);
      end_test("array match");
   endtask : t_array

   task automatic t_scratch();
      send("QRS");
      run(OP_SCRATCH, 1'b0, 8'h00, 8'h03, 1'b0, 8'h00, "");
      for (int k = 0; k < 3; k++) expect_wr(TGT_SCRATCH, 8'(k), 16'(8'h51 + k), 16'h00FF);
      for (int k = 0; k < 126; k++) i_sip_sender.push(8'(k));
      send("2 ");
      run(OP_SCRATCH, 1'b0, 8'h00, 8'h80, 1'b0, 8'h00, "");
      for (int k = 0; k < 126; k++) expect_wr(TGT_SCRATCH, 8'(k), 16'(k), 16'h00FF);
      run(OP_CONV, 1'b1, 8'h09, 8'h00, 1'b0, 8'h00, "");
      expect_wr(TGT_VAR, 8'h09, 16'h0002, 16'hFFFF);
      end_test("scratch");
   endtask : t_scratch

   initial begin
      rst_n_i = 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      t_conv();
      t_limit();
      t_text();
      t_match();
      t_array();
      t_scratch();
      summarize();
   end
endmodule : sip_top_tb_top
